// ===== common/psgc_pkg.sv
package psgc_pkg;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_VDC  = 8'h00;
  localparam logic [7:0] OFS_SCC0 = 8'h04;
  localparam logic [7:0] OFS_SCC1 = 8'h08;
  localparam logic [7:0] OFS_SCC3 = 8'h0C;
  localparam logic [7:0] OFS_OSD  = 8'h10;
  localparam logic [7:0] OFS_HSOC = 8'h14;
  localparam logic [7:0] OFS_TAM  = 8'h18;
  localparam logic [7:0] OFS_TBM  = 8'h1C;
  localparam logic [7:0] OFS_MSC  = 8'h20;
  localparam logic [7:0] OFS_TDC  = 8'h24;
  localparam logic [7:0] OFS_ADC1 = 8'h28;
  localparam logic [7:0] OFS_FC0  = 8'h2C;
  localparam logic [7:0] OFS_FC2  = 8'h30;
  localparam logic [7:0] OFS_CDIV = 8'h34;
  localparam logic [7:0] OFS_STAT = 8'h38;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int VDC_VDET0    = 0;
  localparam int VDC_VDET1    = 1;
  localparam int VDC_VDET2    = 2;
  localparam int VDC_LOWCONS  = 3;
  localparam int SCC0_PSTOP   = 0;
  localparam int SCC1_LOSCOFF = 0;
  localparam int SCC3_WAIT    = 0;
  localparam int OSD_SEL      = 0;
  localparam int HSOC_RUN     = 0;
  localparam int TM_CUTOFF    = 0;
  localparam int MSC_TC       = 0;
  localparam int MSC_TD       = 1;
  localparam int MSC_SSU      = 2;
  localparam int TDC_SEL_LSB  = 0;
  localparam int ADC1_STBY    = 0;
  localparam int FC0_FSTOP    = 0;
  localparam int FC0_REWRITE  = 1;
  localparam int FC2_LCREAD   = 0;
  localparam int ST_WAIT      = 0;
  localparam int ST_STOP      = 1;
  localparam int ST_FPWR      = 2;
  localparam int ST_FACC      = 3;
  localparam int ST_DIVBAD    = 4;

  // ----------------------------------------
  // Reset values, divider code and counter limit
  // ----------------------------------------
  localparam logic [3:0] RST_VDC  = 4'h1;
  localparam logic       RST_HSOC = 1'b0;
  localparam logic [2:0] RST_CDIV = 3'h3;
  localparam logic [2:0] CDIV_2   = 3'h1;
  localparam logic [4:0] DIV_MAX  = 5'h1F;

  typedef struct packed {
    logic f1;
    logic f2;
    logic f4;
    logic f8;
    logic f32;
  } psgc_clk_t;

  typedef struct packed {
    logic timer_a_tick;
    logic timer_b_tick;
    logic timer_c_standby;
    logic timer_d_standby;
    logic sync_serial_standby;
    logic adc_run;
  } psgc_mod_t;

endpackage

// ===== rtl/psgc_top.sv
module psgc_top
  import psgc_pkg::*;
#(
  parameter int PORT_W = 8
) (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic [31:0]            hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire logic              wait_instr,
  input  wire logic              stop_entry,
  input  wire logic              wake_event,
  input  wire logic [PORT_W-1:0] port_dir_in,
  input  wire logic [PORT_W-1:0] port_out_in,
  output logic [PORT_W-1:0]      port_dir,
  output logic [PORT_W-1:0]      port_out,
  output logic                   vdet0_on,
  output logic                   vdet1_on,
  output logic                   vdet2_on,
  output logic                   low_consumption_active,
  output logic                   low_speed_osc_on,
  output logic                   system_clock_select,
  output logic                   high_speed_osc_on,
  output psgc_clk_t              periph_clk_en,
  output psgc_mod_t              module_ctl,
  output logic [2:0]             timer_d_clock_select,
  output logic                   flash_power_on,
  output logic                   flash_access_en,
  output logic                   low_current_read_enable,
  output logic [2:0]             cpu_clock_div,
  output logic                   wait_mode,
  output logic                   stop_mode
);

  // ----------------------------------------
  // Elaboration check
  // ----------------------------------------
  if (PORT_W < 1 || PORT_W > 32) begin : g_bad_width
    $error("PORT_W must be between 1 and 32");
  end

  // ----------------------------------------
  // AHB-Lite slave
  // ----------------------------------------
  logic [7:0] waddr_q;
  logic       wpend_q;
  logic       rd_go;
  logic       wr_go;
  logic [7:0] wdata;
  logic [31:0] rmux;

  assign rd_go = hsel && hready && htrans[1] && !hwrite;
  assign wr_go = hsel && hready && htrans[1] && hwrite;
  assign wdata = hwdata[7:0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      waddr_q   <= 8'h00;
      wpend_q   <= 1'b0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (hready) begin
        wpend_q <= wr_go;
        waddr_q <= haddr[7:0];
      end
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  logic [3:0] vdc_q;
  logic       pstop_q;
  logic       loscoff_q;
  logic       osd_sel_q;
  logic       hsrun_q;
  logic       ta_cut_q;
  logic       tb_cut_q;
  logic [2:0] msc_q;
  logic [2:0] tdsel_q;
  logic       adc_standby_control_q;
  logic       fstop_q;
  logic       rewrite_q;
  logic       lcread_q;
  logic [2:0] cdiv_q;
  logic       wait_q;
  logic       stop_q;
  logic       fpwr_q;
  logic       wait_wr;

  function automatic logic wr_hit(input logic [7:0] ofs);
    wr_hit = 1'b0;
    if (wpend_q && waddr_q == ofs) begin
      wr_hit = 1'b1;
    end
  endfunction

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vdc_q     <= RST_VDC;
      pstop_q   <= 1'b0;
      loscoff_q <= 1'b0;
      osd_sel_q <= 1'b0;
      hsrun_q   <= RST_HSOC;
      ta_cut_q  <= 1'b0;
      tb_cut_q  <= 1'b0;
      msc_q     <= 3'h0;
      tdsel_q   <= 3'h0;
      adc_standby_control_q  <= 1'b0;
      fstop_q   <= 1'b0;
      rewrite_q <= 1'b0;
      lcread_q  <= 1'b0;
      cdiv_q    <= RST_CDIV;
    end else begin
      if (wr_hit(OFS_VDC)) vdc_q <= wdata[3:0];
      if (wr_hit(OFS_SCC0)) pstop_q <= wdata[SCC0_PSTOP];
      if (wr_hit(OFS_SCC1)) loscoff_q <= wdata[SCC1_LOSCOFF];
      if (wr_hit(OFS_OSD)) osd_sel_q <= wdata[OSD_SEL];
      if (wr_hit(OFS_HSOC)) hsrun_q <= wdata[HSOC_RUN];
      if (wr_hit(OFS_TAM)) ta_cut_q <= wdata[TM_CUTOFF];
      if (wr_hit(OFS_TBM)) tb_cut_q <= wdata[TM_CUTOFF];
      if (wr_hit(OFS_MSC)) msc_q <= wdata[2:0];
      if (wr_hit(OFS_TDC)) tdsel_q <= wdata[TDC_SEL_LSB +: 3];
      if (wr_hit(OFS_ADC1)) adc_standby_control_q <= wdata[ADC1_STBY];
      if (wr_hit(OFS_FC0)) begin
        fstop_q   <= wdata[FC0_FSTOP];
        rewrite_q <= wdata[FC0_REWRITE];
      end
      if (wr_hit(OFS_FC2)) lcread_q <= wdata[FC2_LCREAD];
      if (wr_hit(OFS_CDIV)) cdiv_q <= wdata[2:0];
    end
  end

  // ----------------------------------------
  // Wait and stop state
  // ----------------------------------------
  // Entry beats a coincident wake so the request is never lost;
  // a wake still present exits on the following edge.
  assign wait_wr = wr_hit(OFS_SCC3) && wdata[SCC3_WAIT];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wait_q <= 1'b0;
      stop_q <= 1'b0;
    end else begin
      if (wait_wr || wait_instr) begin
        wait_q <= 1'b1;
      end else if (wake_event) begin
        wait_q <= 1'b0;
      end
      if (stop_entry) begin
        stop_q <= 1'b1;
      end else if (wake_event) begin
        stop_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  always_comb begin
    rmux = 32'h0000_0000;
    if (haddr[7:0] == OFS_VDC) begin
      rmux[3:0] = vdc_q;
    end else if (haddr[7:0] == OFS_SCC0) begin
      rmux[SCC0_PSTOP] = pstop_q;
    end else if (haddr[7:0] == OFS_SCC1) begin
      rmux[SCC1_LOSCOFF] = loscoff_q;
    end else if (haddr[7:0] == OFS_SCC3) begin
      rmux[SCC3_WAIT] = wait_q;
    end else if (haddr[7:0] == OFS_OSD) begin
      rmux[OSD_SEL] = osd_sel_q;
    end else if (haddr[7:0] == OFS_HSOC) begin
      rmux[HSOC_RUN] = hsrun_q;
    end else if (haddr[7:0] == OFS_TAM) begin
      rmux[TM_CUTOFF] = ta_cut_q;
    end else if (haddr[7:0] == OFS_TBM) begin
      rmux[TM_CUTOFF] = tb_cut_q;
    end else if (haddr[7:0] == OFS_MSC) begin
      rmux[2:0] = msc_q;
    end else if (haddr[7:0] == OFS_TDC) begin
      rmux[TDC_SEL_LSB +: 3] = tdsel_q;
    end else if (haddr[7:0] == OFS_ADC1) begin
      rmux[ADC1_STBY] = adc_standby_control_q;
    end else if (haddr[7:0] == OFS_FC0) begin
      rmux[FC0_FSTOP]   = fstop_q;
      rmux[FC0_REWRITE] = rewrite_q;
    end else if (haddr[7:0] == OFS_FC2) begin
      rmux[FC2_LCREAD] = lcread_q;
    end else if (haddr[7:0] == OFS_CDIV) begin
      rmux[2:0] = cdiv_q;
    end else if (haddr[7:0] == OFS_STAT) begin
      rmux[ST_WAIT]   = wait_q;
      rmux[ST_STOP]   = stop_q;
      rmux[ST_FPWR]   = fpwr_q;
      rmux[ST_FACC]   = fpwr_q && !fstop_q;
      rmux[ST_DIVBAD] = lcread_q && (cdiv_q <= CDIV_2);
    end
  end

  // Read data is sampled at the address phase, so a read right after
  // a write to the same register returns the old value.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_go) begin
      hrdata <= rmux;
    end
  end

  // ----------------------------------------
  // Peripheral clock enables
  // ----------------------------------------
  logic [4:0] div_q;
  logic       clk_run;

  assign clk_run = !stop_q && !(wait_q && pstop_q);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_q <= 5'h00;
    end else begin
      div_q <= div_q + 5'h01;
    end
  end

  // Enables are whole one-cycle pulses, so gating never cuts a tick short
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      periph_clk_en <= '0;
    end else begin
      periph_clk_en.f1  <= clk_run;
      periph_clk_en.f2  <= clk_run && (div_q[0] == 1'b1);
      periph_clk_en.f4  <= clk_run && (div_q[1:0] == 2'h3);
      periph_clk_en.f8  <= clk_run && (div_q[2:0] == 3'h7);
      periph_clk_en.f32 <= clk_run && (div_q == DIV_MAX);
    end
  end

  // ----------------------------------------
  // Module gating
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      module_ctl           <= '0;
      timer_d_clock_select <= 3'h0;
    end else begin
      module_ctl.timer_a_tick        <= clk_run && !ta_cut_q;
      module_ctl.timer_b_tick        <= clk_run && !tb_cut_q;
      module_ctl.timer_c_standby     <= msc_q[MSC_TC];
      module_ctl.timer_d_standby     <= msc_q[MSC_TD];
      module_ctl.sync_serial_standby <= msc_q[MSC_SSU];
      module_ctl.adc_run             <= adc_standby_control_q;
      timer_d_clock_select           <= tdsel_q;
    end
  end

  // ----------------------------------------
  // Oscillators and voltage detection
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vdet0_on               <= RST_VDC[VDC_VDET0];
      vdet1_on               <= RST_VDC[VDC_VDET1];
      vdet2_on               <= RST_VDC[VDC_VDET2];
      low_consumption_active <= 1'b0;
      low_speed_osc_on       <= 1'b1;
      system_clock_select    <= 1'b0;
      high_speed_osc_on      <= RST_HSOC;
    end else begin
      vdet0_on               <= vdc_q[VDC_VDET0];
      vdet1_on               <= vdc_q[VDC_VDET1];
      vdet2_on               <= vdc_q[VDC_VDET2];
      low_consumption_active <= vdc_q[VDC_LOWCONS] && wait_q;
      low_speed_osc_on       <= !loscoff_q;
      system_clock_select    <= osd_sel_q;
      high_speed_osc_on      <= hsrun_q;
    end
  end

  // ----------------------------------------
  // Flash control
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fpwr_q                  <= 1'b1;
      flash_power_on          <= 1'b1;
      flash_access_en         <= 1'b1;
      low_current_read_enable <= 1'b0;
      cpu_clock_div           <= RST_CDIV;
    end else begin
      fpwr_q                  <= !((wait_q || stop_q) && !rewrite_q);
      flash_power_on          <= !((wait_q || stop_q) && !rewrite_q);
      flash_access_en         <= !fstop_q && !((wait_q || stop_q) && !rewrite_q);
      low_current_read_enable <= lcread_q;
      cpu_clock_div           <= cdiv_q;
    end
  end

  // ----------------------------------------
  // Port hold and mode outputs
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_dir  <= '0;
      port_out  <= '0;
      wait_mode <= 1'b0;
      stop_mode <= 1'b0;
    end else begin
      if (!(wait_q || stop_q)) begin
        port_dir <= port_dir_in;
        port_out <= port_out_in;
      end
      wait_mode <= wait_q;
      stop_mode <= stop_q;
    end
  end

endmodule

// ===== dv/psgc_chk.sv
module psgc_chk
  import psgc_pkg::*;
#(
  parameter int PORT_W = 8
) (
  input wire logic              hclk,
  input wire logic              hresetn,
  input wire logic              wait_instr,
  input wire logic              wait_mode,
  input wire logic              stop_mode,
  input wire logic [PORT_W-1:0] port_dir,
  input wire logic [PORT_W-1:0] port_out,
  input wire psgc_clk_t         periph_clk_en,
  input wire logic              flash_power_on,
  input wire logic              flash_access_en
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // --------------------------------
  // Sequences
  // --------------------------------
  sequence s_asleep;
    (wait_mode || stop_mode) && $past(wait_mode || stop_mode);
  endsequence
  sequence s_awake;
    !wait_mode && !stop_mode && $past(hresetn);
  endsequence
  // --------------------------------
  // Assertions
  // --------------------------------
  a_port_freeze: assert property (s_asleep |-> $stable(port_dir) && $stable(port_out))
    else $error("port state moved while asleep");
  a_stop_halt: assert property (stop_mode |-> periph_clk_en == '0)
    else $error("peripheral enable in stop");
  a_f1_running: assert property (s_awake |-> periph_clk_en.f1)
    else $error("f1 missing while awake");
  a_wait_entry: assert property (wait_instr |-> ##2 wait_mode)
    else $error("wait not entered");
  a_flash_block: assert property (flash_access_en |-> flash_power_on)
    else $error("flash access without power");
  a_flash_restore: assert property (s_awake |-> flash_power_on)
    else $error("flash power off while awake");
  a_f2_whole: assert property (periph_clk_en.f2 |=> !periph_clk_en.f2)
    else $error("f2 pulse too long");
  a_f32_whole: assert property (periph_clk_en.f32 |=> !periph_clk_en.f32 [*8])
    else $error("f32 pulse spacing wrong");
endmodule

bind psgc_top psgc_chk #(.PORT_W(PORT_W)) u_chk (
  .hclk(hclk), .hresetn(hresetn), .wait_instr(wait_instr), .wait_mode(wait_mode),
  .stop_mode(stop_mode), .port_dir(port_dir), .port_out(port_out),
  .periph_clk_en(periph_clk_en), .flash_power_on(flash_power_on),
  .flash_access_en(flash_access_en)
);

// ===== dv/psgc_top_tb.sv
module psgc_top_tb;
  import psgc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [2:0]  hsize = 3'h0;
  logic        hresp;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        wait_instr = 1'b0;
  logic        stop_entry = 1'b0;
  logic        wake_event = 1'b0;
  logic [7:0]  pdi = 8'h3C;
  logic [7:0]  poi = 8'hA5;
  logic [7:0]  pd;
  logic [7:0]  po;
  logic        v0, v1, v2, lca, lso, scs, hso, fpo, fae, lcr, wm, sm;
  psgc_clk_t   pce;
  psgc_mod_t   mc;
  logic [2:0]  tds;
  logic [2:0]  cdiv;
  logic [31:0] rv;
  int          error_cnt = 0;
  int          comparisons = 0;
  int          cycles = 0;

  always #2.5 hclk = ~hclk;

  psgc_top #(.PORT_W(8)) u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .wait_instr(wait_instr), .stop_entry(stop_entry),
    .wake_event(wake_event), .port_dir_in(pdi), .port_out_in(poi), .port_dir(pd),
    .port_out(po), .vdet0_on(v0), .vdet1_on(v1), .vdet2_on(v2),
    .low_consumption_active(lca), .low_speed_osc_on(lso), .system_clock_select(scs),
    .high_speed_osc_on(hso), .periph_clk_en(pce), .module_ctl(mc),
    .timer_d_clock_select(tds), .flash_power_on(fpo), .flash_access_en(fae),
    .low_current_read_enable(lcr), .cpu_clock_div(cdiv), .wait_mode(wm), .stop_mode(sm)
  );

  // --------------------------------
  // Helpers
  // --------------------------------
  task close_out;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      close_out();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize  <= 3'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rv = hrdata;
  endtask

  task settle;
    repeat (3) @(posedge hclk);
    #1;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
    settle();
  endtask

  task wake;
    @(posedge hclk) wake_event <= 1'b1;
    @(posedge hclk) wake_event <= 1'b0;
    settle();
  endtask

  // --------------------------------
  // Scenarios
  // --------------------------------
  task t_vdet;
    xfer(OFS_VDC, 1'b0, 32'h0); chk(rv, 32'h1);
    xfer(8'h3C, 1'b0, 32'h0); chk(rv, 32'h0);
    for (int i = 0; i < 8; i++) begin
      wr(OFS_VDC, 32'(i));
      chk({v2, v1, v0}, 32'(i));
    end
  endtask

  task t_osc;
    wr(OFS_SCC1, 32'h1); chk(lso, 1'b0);
    wr(OFS_OSD, 32'h1); chk(scs, 1'b1);
    wr(OFS_OSD, 32'h0); chk(scs, 1'b0);
    wr(OFS_HSOC, 32'h1); chk(hso, 1'b1);
    wr(OFS_HSOC, 32'h0); chk(hso, 1'b0);
  endtask

  task t_mod;
    logic seen;
    seen = 1'b0;
    chk({mc.timer_a_tick, mc.timer_b_tick}, 2'h3);
    wr(OFS_TAM, 32'h1);
    wr(OFS_TBM, 32'h1);
    wr(OFS_TDC, 32'h7); chk(tds, 3'h7);
    wr(OFS_TDC, 32'h0); chk(tds, 3'h0);
    for (int i = 0; i < 40; i++) begin
      @(posedge hclk) #1 seen = seen | mc.timer_a_tick | mc.timer_b_tick;
    end
    chk(seen, 1'b0);
    for (int i = 0; i < 3; i++) begin
      wr(OFS_MSC, 32'h1 << i);
      chk({mc.sync_serial_standby, mc.timer_d_standby, mc.timer_c_standby}, 32'h1 << i);
    end
    wr(OFS_ADC1, 32'h1); chk(mc.adc_run, 1'b1);
    wr(OFS_ADC1, 32'h0); chk(mc.adc_run, 1'b0);
  endtask

  task t_wait_reg;
    wr(OFS_SCC0, 32'h1);
    wr(OFS_VDC, 32'h9);
    wr(OFS_FC0, 32'h0);
    wr(OFS_SCC3, 32'h1); chk(wm, 1'b1);
    chk(pce, 5'h0);
    chk(lca, 1'b1);
    chk(fpo, 1'b0);
    @(posedge hclk);
    pdi <= 8'hC3;
    poi <= 8'h5A;
    settle(); chk({pd, po}, 16'h3CA5);
    wake(); chk(wm, 1'b0);
    chk(fpo, 1'b1);
    chk({pd, po}, 16'hC35A);
  endtask

  task t_wait_ins;
    wr(OFS_SCC0, 32'h0);
    wr(OFS_FC0, 32'h2);
    @(posedge hclk) wait_instr <= 1'b1;
    @(posedge hclk) wait_instr <= 1'b0;
    settle(); chk(wm, 1'b1);
    chk(pce.f1, 1'b1);
    chk(fpo, 1'b1);
    wake();
    wr(OFS_FC0, 32'h0);
    @(posedge hclk) stop_entry <= 1'b1;
    @(posedge hclk) stop_entry <= 1'b0;
    settle(); chk({sm, pce, fpo}, 32'h40);
    wake(); chk({sm, fpo}, 2'h1);
  endtask

  task t_flash;
    wr(OFS_FC0, 32'h1); chk(fae, 1'b0);
    xfer(OFS_FC0, 1'b0, 32'h0); chk(rv, 32'h1);
    chk(hresp, 1'b0);
    wr(OFS_FC0, 32'h0); chk(fae, 1'b1);
    wr(OFS_CDIV, 32'h2);
    wr(OFS_FC2, 32'h1); chk({lcr, cdiv}, 4'hA);
    xfer(OFS_STAT, 1'b0, 32'h0); chk(rv[4], 1'b0);
    chk(rv, 32'h0000_000C);
    wr(OFS_FC2, 32'h0); chk(lcr, 1'b0);
  endtask

  task t_clk;
    int n1, n2, n4, n8, n32;
    n1 = 0;
    n2 = 0;
    n4 = 0;
    n8 = 0;
    n32 = 0;
    for (int i = 0; i < 32; i++) begin
      @(posedge hclk);
      #1;
      n1 += pce.f1;
      n2 += pce.f2;
      n4 += pce.f4;
      n8 += pce.f8;
      n32 += pce.f32;
    end
    chk(n1, 32'h20);
    chk(n2, 32'h10);
    chk(n4, 32'h8);
    chk(n8, 32'h4);
    chk(n32, 32'h1);
  endtask

  // Reset in mid-run, taken while asleep
  task t_reset;
    @(posedge hclk) wait_instr <= 1'b1;
    @(posedge hclk) wait_instr <= 1'b0;
    settle(); chk(wm, 1'b1);
    @(posedge hclk) hresetn <= 1'b0;
    settle(); chk({wm, sm, pce}, 32'h0);
    chk({v2, v1, v0}, 3'h1);
    chk({fpo, fae, lso, hso}, 4'hE);
    chk(cdiv, 3'h3);
    @(posedge hclk) hresetn <= 1'b1;
    settle(); chk(pce.f1, 1'b1);
    xfer(OFS_VDC, 1'b0, 32'h0); chk(rv, 32'h1);
  endtask

  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    t_vdet();
    t_osc();
    t_clk();
    t_mod();
    t_flash();
    t_wait_reg();
    t_wait_ins();
    t_reset();
    close_out();
  end
endmodule
